// ---- core/dpc_host.sv ----
// Purpose: host controller driving one port of an async dual-port ram
// Assumes: device port pins wired directly; busy is a device output
// Notes: one request at a time; o_done pulses with read data
`timescale 1ns/10ps
`default_nettype none
module dpc_host
   import dpc_pkg::*;
#(
   parameter int AW = 13,
   parameter int DW = 18
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_req,
   input wire logic [2:0] i_cmd,
   input wire logic [AW-1:0] i_addr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic [1:0] i_be,
   output logic o_ready,
   output logic o_done,
   output logic [DW-1:0] o_rdata,
   output logic o_flag,
   output logic [AW-1:0] o_a,
   output logic o_chip_sel_n,
   output logic o_flag_access_select_n,
   output logic o_upper_byte_enable_n,
   output logic o_lower_byte_enable_n,
   output logic o_rw_n,
   output logic o_oe_n,
   output logic [DW-1:0] o_io,
   output logic o_io_oe,
   input wire logic [DW-1:0] i_io,
   input wire logic i_busy_n
);
   // byte lanes need an even width; wider addresses are not served
   if (AW < 1 || AW > 16 || DW < 2 || (DW % 2) != 0) begin : g_bad_width
      $error("dpc_host: bad widths");
   end
   // ================================================================
   // reset release and pin synchronisers
   logic rs1_q, rst_q;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rs1_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rst_q <= rs1_q;
      end
   end
   logic [DW-1:0] io_s;
   logic busy_s;
   dpc_sync #(.W(DW), .INIT('0)) u_sio (
      .i_mclk(i_mclk),
      .i_rst_b(rst_q),
      .i_d(i_io),
      .o_q(io_s)
   );
   dpc_sync #(.W(1), .INIT(1'b1)) u_sbusy (
      .i_mclk(i_mclk),
      .i_rst_b(rst_q),
      .i_d(i_busy_n),
      .o_q(busy_s)
   );
   // ================================================================
   // sequencer
   dpc_state_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic [2:0] cmd_q, cmd_d;
   logic [AW-1:0] a_q, a_d;
   logic [DW-1:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] be_q, be_d;
   logic cs_q, cs_d, fs_q, fs_d, hi_en_q, hi_en_d, lo_en_q, lo_en_d, rw_q, rw_d, oe_q, oe_d;
   logic ioe_q, ioe_d, rdy_q, rdy_d, dn_q, dn_d, fl_q, fl_d;
   logic is_wr, is_flag;
   assign is_wr = (cmd_q == CMD_WR) || (cmd_q == CMD_FWR);
   assign is_flag = (cmd_q == CMD_FRD) || (cmd_q == CMD_FWR);

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      cmd_d = cmd_q;
      a_d = a_q;
      wd_d = wd_q;
      rd_d = rd_q;
      be_d = be_q;
      cs_d = cs_q;
      fs_d = fs_q;
      hi_en_d = hi_en_q;
      lo_en_d = lo_en_q;
      rw_d = rw_q;
      oe_d = oe_q;
      ioe_d = ioe_q;
      rdy_d = rdy_q;
      dn_d = 1'b0;
      fl_d = fl_q;
      unique case (st_q)
         DPC_IDLE: begin
            if (i_req && rdy_q) begin
               // address moves only while all strobes are idle
               cmd_d = i_cmd;
               a_d = i_addr;
               wd_d = i_wdata;
               be_d = i_be;
               rdy_d = 1'b0;
               st_d = DPC_SETUP;
            end
         end
         DPC_SETUP: begin
            // choose array or flag selection, held until the end
            if (is_flag) begin
               cs_d = 1'b1;
               hi_en_d = 1'b1;
               lo_en_d = 1'b1;
               fs_d = 1'b0;
            end else begin
               cs_d = 1'b0;
               fs_d = 1'b1;
               hi_en_d = ~be_q[1];
               lo_en_d = ~be_q[0];
            end
            // output enable stays high on writes so the pulse can stay short
            oe_d = is_wr;
            rw_d = ~is_wr;
            // drive data only once the write strobe has turned the device off
            ioe_d = 1'b0;
            // data goes out a cycle in; busy must be seen before the end
            cnt_d = is_wr ? 8'(WSTR_CYC) : 8'(RD_CYC);
            st_d = DPC_STROBE;
         end
         DPC_STROBE: begin
            if (is_wr) begin
               ioe_d = 1'b1;
            end
            if (cnt_q > 8'h1) begin
               cnt_d = cnt_q - 8'h1;
            end else if (is_wr && !is_flag && !busy_s) begin
               // stretch write while busy, then hold after release
               cnt_d = 8'(WH_CYC);
            end else begin
               if (!is_wr) begin
                  rd_d = io_s;
                  fl_d = io_s[0];
               end
               rw_d = 1'b1;
               cnt_d = is_flag ? 8'(SWRD_CYC) : 8'(WDD_CYC);
               st_d = DPC_HOLD;
            end
         end
         DPC_HOLD: begin
            // strobe ends before selections; flag pause and port delay
            cs_d = 1'b1;
            fs_d = 1'b1;
            hi_en_d = 1'b1;
            lo_en_d = 1'b1;
            oe_d = 1'b1;
            ioe_d = 1'b0;
            if (cnt_q > 8'h1) begin
               cnt_d = cnt_q - 8'h1;
            end else begin
               st_d = DPC_DONE;
            end
         end
         DPC_DONE: begin
            dn_d = 1'b1;
            rdy_d = 1'b1;
            st_d = DPC_IDLE;
         end
         default: begin
            st_d = DPC_IDLE;
            rdy_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge rst_q) begin
      if (!rst_q) begin
         st_q <= DPC_IDLE;
         cnt_q <= 8'h0;
         cmd_q <= CMD_RD;
         a_q <= '0;
         wd_q <= '0;
         rd_q <= '0;
         be_q <= 2'h0;
         cs_q <= 1'b1;
         fs_q <= 1'b1;
         hi_en_q <= 1'b1;
         lo_en_q <= 1'b1;
         rw_q <= 1'b1;
         oe_q <= 1'b1;
         ioe_q <= 1'b0;
         rdy_q <= 1'b1;
         dn_q <= 1'b0;
         fl_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         cmd_q <= cmd_d;
         a_q <= a_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         be_q <= be_d;
         cs_q <= cs_d;
         fs_q <= fs_d;
         hi_en_q <= hi_en_d;
         lo_en_q <= lo_en_d;
         rw_q <= rw_d;
         oe_q <= oe_d;
         ioe_q <= ioe_d;
         rdy_q <= rdy_d;
         dn_q <= dn_d;
         fl_q <= fl_d;
      end
   end

   assign o_ready = rdy_q;
   assign o_done = dn_q;
   assign o_rdata = rd_q;
   assign o_flag = fl_q;
   assign o_a = a_q;
   assign o_chip_sel_n = cs_q;
   assign o_flag_access_select_n = fs_q;
   assign o_upper_byte_enable_n = hi_en_q;
   assign o_lower_byte_enable_n = lo_en_q;
   assign o_rw_n = rw_q;
   assign o_oe_n = oe_q;
   assign o_io = wd_q;
   assign o_io_oe = ioe_q;

   // ================================================================
   // checks
   addr_stable_a: assert property (@(posedge i_mclk) disable iff (!rst_q)
      !$stable(a_q) |-> (cs_q && fs_q)) else $error("address moved while selected");
   sel_excl_a: assert property (@(posedge i_mclk) disable iff (!rst_q)
      !(~cs_q && ~fs_q)) else $error("array and flag selected together");
   wr_oe_a: assert property (@(posedge i_mclk) disable iff (!rst_q)
      !rw_q |-> oe_q) else $error("output enable low during write");
   drive_a: assert property (@(posedge i_mclk) disable iff (!rst_q)
      $rose(ioe_q) |-> !$past(rw_q) && !rw_q) else $error("data driven before strobe");
   flag_sel_a: assert property (@(posedge i_mclk) disable iff (!rst_q)
      !fs_q |-> cs_q && hi_en_q && lo_en_q) else $error("array select during flag access");
   busy_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_q)
      (st_q == DPC_STROBE && !rw_q && !cs_q && !busy_s) ##1 busy_s |-> !rw_q [*1])
      else $error("write ended while busy");
   hold_len_a: assert property (@(posedge i_mclk) disable iff (!rst_q)
      (st_q == DPC_STROBE && !cs_q && !rw_q && !busy_s) |=> !rw_q)
      else $error("write strobe released under busy");
   done_a: assert property (@(posedge i_mclk) disable iff (!rst_q)
      $fell(rw_q) ##0 !cs_q |-> ##[2:40] dn_q) else $error("no completion");
endmodule
`default_nettype wire

// ---- core/dpc_pkg.sv ----
// Purpose: constants for the dual-port ram host port controller
// Assumes: 10 MHz clock, one port of the ram driven by this host
// Notes: times in ns, cycle counts derived from the clock period
package dpc_pkg;
   localparam int CLK_NS = 100;
   // ================================================================
   // write cycle timing (ns)
   localparam int WP_NS = 12;        // write pulse width
   localparam int WZ_NS = 10;        // write enable to output high-z
   localparam int DW_NS = 10;        // data valid to end of write
   localparam int WH_NS = 12;        // write hold after busy
   localparam int SWRD_NS = 5;       // flag write to read
   localparam int WDD_NS = 30;       // write pulse to data delay
   localparam int BAA_NS = 15;       // busy valid after select or address match
   // ================================================================
   // cycle counts, minimums round up, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int WP_CYC = cyc_up(WP_NS);
   localparam int WPOE_CYC = cyc_up((WP_NS > WZ_NS + DW_NS) ? WP_NS : WZ_NS + DW_NS);
   localparam int WH_CYC = cyc_up(WH_NS);
   localparam int SWRD_CYC = cyc_up(SWRD_NS);
   localparam int WDD_CYC = cyc_up(WDD_NS);
   // strobe covers data set-up after drive and busy seen through two flops
   localparam int WSTR_CYC = (WP_CYC + 1 > cyc_up(BAA_NS) + 2) ?
      WP_CYC + 1 : cyc_up(BAA_NS) + 2;
   // read data passes two flops before it is taken
   localparam int RD_CYC = 3;
   localparam logic [2:0] CMD_WR = 3'h0;
   localparam logic [2:0] CMD_RD = 3'h1;
   localparam logic [2:0] CMD_FWR = 3'h2;
   localparam logic [2:0] CMD_FRD = 3'h3;
   typedef enum logic [2:0] {
      DPC_IDLE = 3'b000,
      DPC_SETUP = 3'b001,
      DPC_STROBE = 3'b011,
      DPC_HOLD = 3'b010,
      DPC_DONE = 3'b110
   } dpc_state_t;
endpackage

// ---- core/dpc_sync.sv ----
// Purpose: two flop synchroniser for pin inputs
// Assumes: input is asynchronous to i_mclk
// Notes: first flop read only by the second
`timescale 1ns/10ps
`default_nettype none
module dpc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= INIT;
         o_q <= INIT;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- dv/dpc_dev_model.sv ----
// Purpose: behavioural model of one port of the async dual-port ram
// Assumes: far port seen only as address, activity and flag ownership
// Notes: undriven data pins toggle so a stale value never passes
`timescale 1ns/10ps
`default_nettype none
module dpc_dev_model #(
   parameter int WRITE_HOLD_AFTER_BUSY_NS = 12
) (
   input wire logic [12:0] i_a,
   input wire logic i_chip_sel_n,
   input wire logic i_flag_access_select_n,
   input wire logic i_upper_byte_enable_n,
   input wire logic i_lower_byte_enable_n,
   input wire logic i_rw_n,
   input wire logic i_oe_n,
   input wire logic [17:0] i_host_d,
   input wire logic i_host_oe,
   input wire logic i_other_act,
   input wire logic [12:0] i_other_addr,
   input wire logic i_other_flag,
   output logic [17:0] o_d,
   output logic o_busy_n,
   output int o_viol
);
   logic [17:0] mem [0:8191];
   logic [17:0] lat_d;
   logic lat_u, lat_l, flag_q, junk, dev_oe, arr_sel, flg_sel, wr_arr, wr_flg;
   realtime busy_t, wr_t, a_t;
   initial begin
      flag_q = 1'b1;
      junk = 1'b0;
      o_viol = 0;
      busy_t = 0;
      wr_t = 0;
      a_t = 0;
   end
   always #50 junk = ~junk;
   // ================================================================
   // selection and data pins
   assign arr_sel = !i_chip_sel_n && i_flag_access_select_n
      && !(i_upper_byte_enable_n && i_lower_byte_enable_n);
   assign flg_sel = !i_flag_access_select_n
      && (i_chip_sel_n || (i_upper_byte_enable_n && i_lower_byte_enable_n));
   assign wr_arr = arr_sel && !i_rw_n;
   assign wr_flg = flg_sel && !i_rw_n;
   assign dev_oe = (arr_sel || flg_sel) && i_rw_n && !i_oe_n;
   assign o_d = i_host_oe ? i_host_d : !dev_oe ? {9{junk, ~junk}} :
      flg_sel ? {18{flag_q}} : mem[i_a];
   // master side: far port got there first, so busy goes to this port
   assign #15 o_busy_n = !(i_other_act && i_other_addr == i_a
      && !i_chip_sel_n);
   // ================================================================
   // write commit and protocol watch
   always @(posedge o_busy_n) busy_t = $realtime;
   always @(i_a) a_t = $realtime;
   always @(posedge wr_arr or posedge wr_flg) wr_t = $realtime;
   always @* begin
      if (wr_arr || wr_flg) begin
         // data as it stands on the pins, so a late drive is caught
         lat_d = o_d;
         lat_u = !i_upper_byte_enable_n;
         lat_l = !i_lower_byte_enable_n;
      end
   end
   always @(negedge wr_arr) begin
      // reset drops the strobe from unknown; nothing to judge before a write
      if (wr_t > 0) begin
         if (a_t > wr_t || $realtime - wr_t < 12) o_viol++;
         if (o_busy_n === 1'b1) begin
            if ($realtime - busy_t < WRITE_HOLD_AFTER_BUSY_NS) o_viol++;
            // committed at once, well inside the far port's delay
            if (lat_u) mem[i_a][17:9] = lat_d[17:9];
            if (lat_l) mem[i_a][8:0] = lat_d[8:0];
         end
      end
   end
   // a claim is refused while the far port owns the flag
   always @(negedge wr_flg) if (wr_t > 0) flag_q = lat_d[0] | i_other_flag;
   always @(i_host_oe, dev_oe) #1 if (i_host_oe && dev_oe) o_viol++;
endmodule
`default_nettype wire

// ---- dv/dpc_host_test.sv ----
// Purpose: self-checking bench for the dual-port ram host controller
// Assumes: device model is master, far port driven by the bench
// Notes: inputs change at the falling edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %0t got %h expected %h", $time, got, exp); end end
module dpc_host_test;
   import dpc_pkg::*;
   // clock starts high so reset can fall on the first falling edge
   logic i_mclk = 1, i_rst_b = 1, i_req = 0, o_ready, o_done, o_flag, o_chip_sel_n;
   logic [2:0] i_cmd = 3'h0;
   logic [12:0] i_addr = 13'h0, o_a, oth_a = 13'h0;
   logic [17:0] i_wdata = 18'h0, o_rdata, o_io, io_d, rd;
   logic [1:0] i_be = 2'h0;
   logic o_flag_access_select_n, o_upper_byte_enable_n, o_lower_byte_enable_n;
   logic o_rw_n, o_oe_n, o_io_oe, busy_n, oth_act = 0, oth_flag = 0;
   int fails = 0, checks_done = 0, viol;
   always #50 i_mclk = ~i_mclk;
   dpc_host u_dpc_host (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(i_req), .i_cmd(i_cmd),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_be(i_be), .o_ready(o_ready), .o_done(o_done),
      .o_rdata(o_rdata), .o_flag(o_flag), .o_a(o_a), .o_chip_sel_n(o_chip_sel_n),
      .o_flag_access_select_n(o_flag_access_select_n), .o_rw_n(o_rw_n), .o_oe_n(o_oe_n),
      .o_upper_byte_enable_n(o_upper_byte_enable_n), .o_io(o_io), .o_io_oe(o_io_oe),
      .o_lower_byte_enable_n(o_lower_byte_enable_n), .i_io(io_d), .i_busy_n(busy_n));
   dpc_dev_model #(.WRITE_HOLD_AFTER_BUSY_NS(WH_NS)) u_dpc_dev_model (.i_a(o_a),
      .i_chip_sel_n(o_chip_sel_n), .i_flag_access_select_n(o_flag_access_select_n),
      .i_upper_byte_enable_n(o_upper_byte_enable_n), .i_rw_n(o_rw_n), .i_oe_n(o_oe_n),
      .i_lower_byte_enable_n(o_lower_byte_enable_n), .i_host_d(o_io), .i_host_oe(o_io_oe),
      .i_other_act(oth_act), .i_other_addr(oth_a), .i_other_flag(oth_flag), .o_d(io_d),
      .o_busy_n(busy_n), .o_viol(viol));
   // ================================================================
   // shared tasks
   task automatic end_sim();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic op(input logic [2:0] c, input logic [12:0] a, input logic [17:0] d,
         input logic [1:0] be);
      int n;
      @(negedge i_mclk);
      i_req = 1;
      i_cmd = c;
      i_addr = a;
      i_wdata = d;
      i_be = be;
      for (n = 0; n < 50 && o_ready !== 1'b1; n++) @(negedge i_mclk);
      @(negedge i_mclk);
      i_req = 0;
      for (n = 0; n < 60; n++) begin
         @(posedge i_mclk);
         #1;
         if (o_done === 1'b1) break;
      end
      `CHK(o_done, 1'b1)
      rd = o_rdata;
   endtask
   // ================================================================
   // scenarios
   task automatic t_reset();
      `CHK({o_chip_sel_n, o_flag_access_select_n, o_rw_n, o_io_oe}, 4'he)
      `CHK({o_ready, o_done}, 2'h2)
   endtask
   task automatic t_array();
      op(CMD_WR, 13'h1fff, 18'h2a5a5, 2'h3);
      op(CMD_WR, 13'h1fff, 18'h3ffff, 2'h1);
      op(CMD_RD, 13'h1fff, 18'h0, 2'h3);
      `CHK(rd, 18'h2a5ff)
   endtask
   task automatic t_flag();
      op(CMD_FWR, 13'h3, 18'h0, 2'h0);
      op(CMD_FRD, 13'h3, 18'h0, 2'h0);
      `CHK({rd, o_flag}, 19'h0)
      op(CMD_FWR, 13'h3, 18'h1, 2'h0);
      op(CMD_FRD, 13'h3, 18'h0, 2'h0);
      `CHK(rd, 18'h3ffff)
      oth_flag = 1;
      op(CMD_FWR, 13'h3, 18'h0, 2'h0);
      op(CMD_FRD, 13'h3, 18'h0, 2'h0);
      `CHK(o_flag, 1'b1)
      oth_flag = 0;
   endtask
   task automatic t_busy();
      oth_a = 13'h100;
      oth_act = 1;
      fork
         op(CMD_WR, 13'h100, 18'h1c3c3, 2'h3);
         begin
            // mid-cycle, long after the plain strobe would have ended
            repeat (10) @(negedge i_mclk);
            `CHK({o_rw_n, o_done}, 2'h0)
            oth_act = 0;
         end
      join
      op(CMD_RD, 13'h100, 18'h0, 2'h3);
      `CHK(rd, 18'h1c3c3)
      `CHK(viol, 0)
   endtask
   initial begin
      // a real falling edge on reset, so no check runs on unknown state
      @(negedge i_mclk);
      i_rst_b = 0;
      repeat (5) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst_b = 1;
      repeat (4) @(negedge i_mclk);
      t_reset();
      t_array();
      t_flag();
      t_busy();
      end_sim();
   end
   initial begin
      #(3000 * 100);
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      end_sim();
   end
endmodule
`default_nettype wire
